// File: pfh_pkg.sv
// Shared types, field layouts and constants of the power-line frame codec.
package pfh_pkg;

  localparam int          HDR_BYTES        = 4;
  localparam int          FCS_BYTES        = 2;
  localparam int          ADDR_SHORT_BYTES = 2;
  localparam int          ADDR_LONG_BYTES  = 6;
  localparam int          SEG_LEN_W        = 11;
  localparam logic [7:0]  PRE_BYTE         = 8'h55;
  localparam logic [7:0]  PAD_BYTE         = 8'h00;
  localparam logic [15:0] CRC_POLY         = 16'h1021;
  localparam logic [15:0] CRC_INIT         = 16'hFFFF;
  localparam logic [15:0] CRC_RESIDUE      = 16'h0000;

  // Header byte 0, bit 7 down to bit 0.
  typedef struct packed {
    logic       chan_qual_req;
    logic       encrypt;
    logic [2:0] key_selector;
    logic       ack_req;
    logic       high_prio;
    logic       long_addr;
  } pfh_rxctl_s;

  // Header bytes 0 to 3, byte 0 in the top bits.
  typedef struct packed {
    pfh_rxctl_s           ctl;
    logic [7:0]           block_sequence_number;
    logic                 final_segment_flag;
    logic [3:0]           segment_counter;
    logic [SEG_LEN_W-1:0] segment_byte_length;
  } pfh_hdr_s;

  typedef struct packed {
    pfh_rxctl_s           ctl;
    logic                 final_segment_flag;
    logic [SEG_LEN_W-1:0] segment_byte_length;
    logic [SEG_LEN_W-1:0] block_bytes;
    logic [47:0]          destination_station_address;
    logic [47:0]          source_station_address;
  } pfh_tx_cmd_s;

  typedef struct packed {
    logic       preamble;
    logic       last;
    logic [7:0] data;
  } pfh_line_s;

  typedef struct packed {
    pfh_hdr_s    hdr;
    logic [47:0] destination_station_address;
    logic [47:0] source_station_address;
    logic        multicast;
    logic        accepted;
  } pfh_rx_info_s;

  typedef enum {T_IDLE, T_PRE, T_HDR, T_DST, T_SRC, T_DATA, T_PAD, T_FCS} pfh_tx_e;
  typedef enum {R_HDR, R_DST, R_SRC, R_DATA, R_PAD} pfh_rx_e;

  // One byte through the CRC16, most significant bit first.
  function automatic logic [15:0] pfh_crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      c = c[15] ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
    end
    return c;
  endfunction : pfh_crc_byte

endpackage : pfh_pkg

// File: pfh_buf2.sv
// Small valid/ready buffer, two entries by default, for the outgoing line bytes.
module pfh_buf2 #(
  parameter int W     = 10,
  parameter int DEPTH = 2
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          wr;
  logic          rd;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign wr        = in_valid && in_ready;
  assign rd        = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (wr) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (rd) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end

endmodule : pfh_buf2

// File: pfh_codec.sv
// Power-line frame builder and parser: header packing, addressing, padding and CRC16.
// Functional notes
// - A sent frame is preamble, four header bytes, destination, source, data, padding, two CRC bytes.
// - Header byte 0 bit 7 is the channel quality request.
// - Header byte 0 bit 6 says the data field is encrypted.
// - Header byte 0 bits 5 to 3 select one of eight keys.
// - Header byte 0 bit 2 requests an acknowledgement and bit 1 marks high priority.
// - Header byte 0 bit 0 picks six-byte addresses when set and two-byte addresses when clear.
// - Header byte 1 is a sequence number that steps once per new service block sent.
// - Header byte 2 bit 7 is set only on the final or sole segment of a block.
// - Header byte 2 bits 6 to 3 count segments from zero, one more per segment sent.
// - The 11-bit data length sits in byte 2 bits 2 to 0 (high part) and byte 3 (low part).
// - On receive the data length separates real data from padding, which is dropped.
// - Zero bytes fill the block between data and CRC when the data falls short.
// - Padding is only sent in the final segment of a transfer.
// - A destination is accepted when it is this station's address or a multicast address.
module pfh_codec #(
  parameter int PRE_LEN = 8
) (
  input  wire logic                clk_sys,
  input  wire logic                sys_rst,
  input  wire logic [47:0]         station_address,
  input  wire logic                tx_start,
  output logic                     tx_start_ready,
  input  wire pfh_pkg::pfh_tx_cmd_s tx_cmd,
  input  wire logic                tx_data_valid,
  output logic                     tx_data_ready,
  input  wire logic [7:0]          tx_data,
  output logic                     line_valid,
  input  wire logic                line_ready,
  output pfh_pkg::pfh_line_s       line_out,
  input  wire logic                rx_valid,
  input  wire logic [7:0]          rx_byte,
  input  wire logic                rx_last,
  output logic                     rx_info_valid,
  output pfh_pkg::pfh_rx_info_s    rx_info,
  output logic                     rx_data_valid,
  output logic [7:0]               rx_data,
  output logic                     rx_done,
  output logic                     rx_crc_err
);
  import pfh_pkg::*;

  localparam logic [10:0] HDR_LAST   = 11'(HDR_BYTES - 1);
  localparam logic [10:0] FCS_LAST   = 11'(FCS_BYTES - 1);
  localparam logic [10:0] PRE_LAST   = 11'(PRE_LEN - 1);
  localparam logic [10:0] ASHORT_LST = 11'(ADDR_SHORT_BYTES - 1);
  localparam logic [10:0] ALONG_LST  = 11'(ADDR_LONG_BYTES - 1);

  // Transmit side.
  pfh_tx_e     tx_state;
  pfh_tx_cmd_s cmd;
  logic [10:0] cnt;
  logic [15:0] crc;
  logic [7:0]  seq;
  logic [3:0]  segcnt;
  logic        push;
  logic        fire;
  logic        buf_in_ready;
  pfh_line_s   pline;
  pfh_hdr_s    hdr_word;
  logic [10:0] lim_last;
  logic [10:0] addr_last;
  logic [10:0] pad_len;
  pfh_tx_e     after_src;
  pfh_tx_e     after_data;

  assign hdr_word = {cmd.ctl, seq, cmd.final_segment_flag, segcnt,
                     cmd.segment_byte_length};
  assign addr_last = cmd.ctl.long_addr ? ALONG_LST : ASHORT_LST;
  assign pad_len = (cmd.final_segment_flag && cmd.block_bytes > cmd.segment_byte_length)
                   ? cmd.block_bytes - cmd.segment_byte_length : '0;
  assign after_data = (pad_len != '0) ? T_PAD : T_FCS;
  assign after_src  = (cmd.segment_byte_length != '0) ? T_DATA : after_data;
  assign tx_start_ready = (tx_state == T_IDLE);
  assign tx_data_ready  = (tx_state == T_DATA) && buf_in_ready;
  assign fire = push && buf_in_ready;

  always_comb begin
    push       = 1'b0;
    pline      = '0;
    lim_last   = '0;
    unique case (tx_state)
      T_IDLE: begin
      end
      T_PRE: begin
        push           = 1'b1;
        pline.preamble = 1'b1;
        pline.data     = PRE_BYTE;
        lim_last       = PRE_LAST;
      end
      T_HDR: begin
        push       = 1'b1;
        pline.data = 8'(hdr_word >> {2'(HDR_LAST - cnt), 3'b000});
        lim_last   = HDR_LAST;
      end
      T_DST: begin
        push       = 1'b1;
        pline.data = 8'(cmd.destination_station_address >> {3'(addr_last - cnt), 3'b000});
        lim_last   = addr_last;
      end
      T_SRC: begin
        push       = 1'b1;
        pline.data = 8'(cmd.source_station_address >> {3'(addr_last - cnt), 3'b000});
        lim_last   = addr_last;
      end
      T_DATA: begin
        push       = tx_data_valid;
        pline.data = tx_data;
        lim_last   = cmd.segment_byte_length - 11'd1;
      end
      T_PAD: begin
        push       = 1'b1;
        pline.data = PAD_BYTE;
        lim_last   = pad_len - 11'd1;
      end
      T_FCS: begin
        push       = 1'b1;
        pline.data = cnt[0] ? crc[7:0] : crc[15:8];
        pline.last = (cnt == FCS_LAST);
        lim_last   = FCS_LAST;
      end
    endcase
  end

  // Frame sequencer: each field ends after its last byte is taken by the buffer.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_state <= T_IDLE;
      cnt      <= '0;
      cmd      <= '0;
    end else if (tx_state == T_IDLE) begin
      cnt <= '0;
      if (tx_start) begin
        cmd      <= tx_cmd;
        tx_state <= T_PRE;
      end
    end else if (fire) begin
      if (cnt == lim_last) begin
        cnt <= '0;
        unique case (tx_state)
          T_PRE:   tx_state <= T_HDR;
          T_HDR:   tx_state <= T_DST;
          T_DST:   tx_state <= T_SRC;
          T_SRC:   tx_state <= after_src;
          T_DATA:  tx_state <= after_data;
          T_PAD:   tx_state <= T_FCS;
          T_FCS:   tx_state <= T_IDLE;
          T_IDLE:  tx_state <= T_IDLE;
        endcase
      end else begin
        cnt <= cnt + 11'd1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || tx_state == T_IDLE) begin
      crc <= CRC_INIT;
    end else if (fire && tx_state != T_PRE && tx_state != T_FCS) begin
      crc <= pfh_crc_byte(crc, pline.data);
    end
  end

  // Segment counter restarts and the sequence number steps after a final segment.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      seq    <= '0;
      segcnt <= '0;
    end else if (fire && pline.last) begin
      if (cmd.final_segment_flag) begin
        seq    <= seq + 8'd1;
        segcnt <= '0;
      end else begin
        segcnt <= segcnt + 4'd1;
      end
    end
  end

  pfh_buf2 #(
    .W     ($bits(pfh_line_s)),
    .DEPTH (2)
  ) u_line_buf (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .in_valid  (push),
    .in_ready  (buf_in_ready),
    .in_data   (pline),
    .out_valid (line_valid),
    .out_ready (line_ready),
    .out_data  (line_out)
  );

  // Receive side.
  pfh_rx_e      rx_state;
  logic [10:0]  rcnt;
  logic [15:0]  rcrc;
  logic [15:0]  rcrc_next;
  logic [31:0]  hdr_sr;
  logic [47:0]  dst_sr;
  logic [47:0]  src_sr;
  logic [47:0]  dst_next;
  logic [47:0]  src_next;
  pfh_hdr_s     rhdr;
  logic [10:0]  raddr_last;
  logic         mcast;
  logic         own_hit;

  assign rhdr       = hdr_sr;
  assign raddr_last = rhdr.ctl.long_addr ? ALONG_LST : ASHORT_LST;
  assign rcrc_next  = pfh_crc_byte(rcrc, rx_byte);
  assign dst_next   = {dst_sr[39:0], rx_byte};
  assign src_next   = {src_sr[39:0], rx_byte};
  // The group bit is the low bit of the first address byte on the line.
  assign mcast   = rhdr.ctl.long_addr ? dst_next[40] : dst_next[8];
  assign own_hit = rhdr.ctl.long_addr ? (dst_next == station_address)
                                      : (dst_next[15:0] == station_address[15:0]);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_state      <= R_HDR;
      rcnt          <= '0;
      rcrc          <= CRC_INIT;
      hdr_sr        <= '0;
      dst_sr        <= '0;
      src_sr        <= '0;
      rx_info       <= '0;
      rx_info_valid <= 1'b0;
      rx_data_valid <= 1'b0;
      rx_data       <= '0;
      rx_done       <= 1'b0;
      rx_crc_err    <= 1'b0;
    end else begin
      rx_info_valid <= 1'b0;
      rx_data_valid <= 1'b0;
      rx_done       <= 1'b0;
      if (rx_valid && rx_last) begin
        rx_state   <= R_HDR;
        rcnt       <= '0;
        rcrc       <= CRC_INIT;
        rx_done    <= 1'b1;
        rx_crc_err <= (rcrc_next != CRC_RESIDUE) || (rx_state != R_PAD);
      end else if (rx_valid) begin
        rcrc <= rcrc_next;
        rcnt <= rcnt + 11'd1;
        unique case (rx_state)
          R_HDR: begin
            hdr_sr <= {hdr_sr[23:0], rx_byte};
            if (rcnt == HDR_LAST) begin
              rcnt     <= '0;
              rx_state <= R_DST;
            end
          end
          R_DST: begin
            dst_sr <= dst_next;
            if (rcnt == raddr_last) begin
              rcnt     <= '0;
              rx_state <= R_SRC;
              rx_info.destination_station_address <= rhdr.ctl.long_addr ? dst_next
                                                     : {32'h0, dst_next[15:0]};
              rx_info.multicast <= mcast;
              rx_info.accepted  <= mcast || own_hit;
            end
          end
          R_SRC: begin
            src_sr <= src_next;
            if (rcnt == raddr_last) begin
              rcnt          <= '0;
              rx_info_valid <= 1'b1;
              rx_info.hdr   <= rhdr;
              rx_info.source_station_address <= rhdr.ctl.long_addr ? src_next
                                                : {32'h0, src_next[15:0]};
              rx_state <= (rhdr.segment_byte_length != '0) ? R_DATA : R_PAD;
            end
          end
          R_DATA: begin
            rx_data_valid <= rx_info.accepted;
            rx_data       <= rx_byte;
            if (rcnt == rhdr.segment_byte_length - 11'd1) begin
              rcnt     <= '0;
              rx_state <= R_PAD;
            end
          end
          R_PAD: begin
            rcnt <= rcnt;
          end
        endcase
      end
    end
  end

  a_frame_order: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (tx_state == T_HDR && $past(tx_state) != T_HDR) |-> $past(tx_state) == T_PRE)
    else $error("Header did not follow the preamble.");
  a_ctl_byte: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (fire && tx_state == T_HDR && cnt == 11'd0) |-> pline.data == 8'(cmd.ctl))
    else $error("Header byte 0 does not match the control fields.");
  a_seq_step: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (fire && pline.last && cmd.final_segment_flag) |=> seq == 8'($past(seq) + 8'd1))
    else $error("Sequence number did not step after a final segment.");
  a_seg_byte: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (fire && tx_state == T_HDR && cnt == 11'd2) |->
      pline.data == {cmd.final_segment_flag, segcnt, cmd.segment_byte_length[10:8]})
    else $error("Header byte 2 is packed wrongly.");
  a_seg_count: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (fire && pline.last && !cmd.final_segment_flag) |=> segcnt == 4'($past(segcnt) + 4'd1))
    else $error("Segment counter did not step.");
  a_pad_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (tx_state == T_PAD) |-> (cmd.final_segment_flag && pline.data == PAD_BYTE))
    else $error("Padding outside a final segment or not zero.");
  a_fcs_tail: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (fire && pline.last) |=> tx_state == T_IDLE && $past(pline.data) == $past(crc[7:0]))
    else $error("Frame did not end on the CRC low byte.");
  a_rx_strip: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rx_data_valid |-> $past(rx_state) == R_DATA && $past(rx_valid))
    else $error("Data delivered outside the data field.");

endmodule : pfh_codec

// File: pfh_modem_model.sv
// Behavioural modem: stalls and captures outgoing line bytes, plays received bytes.
module pfh_modem_model (
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  input  wire logic               line_valid,
  output logic                    line_ready,
  input  wire pfh_pkg::pfh_line_s line_out,
  output logic                    rx_valid,
  output logic [7:0]              rx_byte,
  output logic                    rx_last
);
  timeunit 1ns;
  timeprecision 1ns;
  import pfh_pkg::*;

  logic [3:0] stall_cnt;
  logic [9:0] cap_q[$];

  initial begin
    line_ready = 1'b0;
    rx_valid   = 1'b0;
    rx_byte    = 8'hA5;
    rx_last    = 1'b0;
    stall_cnt  = 4'h0;
  end

  // Ready is low five cycles in sixteen, long enough to fill the two-entry buffer.
  always @(posedge clk_sys) begin
    if (line_valid === 1'b1 && line_ready === 1'b1) begin
      cap_q.push_back(line_out);
    end
    #1;
    stall_cnt = sys_rst ? 4'h0 : stall_cnt + 4'h1;
    line_ready = !sys_rst && stall_cnt > 4'h4;
  end

  task automatic send(input logic [7:0] b[$]);
    foreach (b[k]) begin
      @(posedge clk_sys);
      #1;
      rx_valid = 1'b1;
      rx_byte  = b[k];
      rx_last  = (k == b.size() - 1);
    end
    @(posedge clk_sys);
    #1;
    rx_valid = 1'b0;
    rx_byte  = ~rx_byte;
    rx_last  = 1'b0;
  endtask : send
endmodule : pfh_modem_model

// File: pfh_codec_test.sv
// Self-checking bench for the frame codec: transmit framing and receive parsing.
module pfh_codec_test;
  timeunit 1ns;
  timeprecision 1ns;
  import pfh_pkg::*;

  logic         clk_sys = 1'b0;
  logic         sys_rst = 1'b1;
  logic [47:0]  station_address = 48'h02468ACE1234;
  logic         tx_start = 1'b0;
  logic         tx_start_ready;
  pfh_tx_cmd_s  tx_cmd = '0;
  logic         tx_data_valid = 1'b0;
  logic         tx_data_ready;
  logic [7:0]   tx_data = 8'h00;
  logic         line_valid;
  logic         line_ready;
  pfh_line_s    line_out;
  logic         rx_valid;
  logic [7:0]   rx_byte;
  logic         rx_last;
  logic         rx_info_valid;
  pfh_rx_info_s rx_info;
  logic         rx_data_valid;
  logic [7:0]   rx_data;
  logic         rx_done;
  logic         rx_crc_err;
  int           error_cnt = 0;
  int           checks_done = 0;
  int           cyc = 0;
  int           done_cnt = 0;
  logic [7:0]   seq = 8'h00;
  logic [3:0]   seg = 4'h0;
  pfh_rx_info_s info_seen;
  logic         err_seen;
  logic [7:0]   rxd_q[$];

  always #50 clk_sys = ~clk_sys;

  pfh_codec #(.PRE_LEN(2)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .station_address(station_address), .tx_start(tx_start), .tx_start_ready(tx_start_ready),
    .tx_cmd(tx_cmd), .tx_data_valid(tx_data_valid), .tx_data_ready(tx_data_ready),
    .tx_data(tx_data), .line_valid(line_valid), .line_ready(line_ready), .line_out(line_out),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_last(rx_last), .rx_info_valid(rx_info_valid),
    .rx_info(rx_info), .rx_data_valid(rx_data_valid), .rx_data(rx_data), .rx_done(rx_done),
    .rx_crc_err(rx_crc_err));

  pfh_modem_model MODEM (.clk_sys(clk_sys), .sys_rst(sys_rst), .line_valid(line_valid),
    .line_ready(line_ready), .line_out(line_out), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_last(rx_last));

  always @(posedge clk_sys) begin
    if (rx_info_valid === 1'b1) begin
      info_seen = rx_info;
    end
    if (rx_data_valid === 1'b1) begin
      rxd_q.push_back(rx_data);
    end
    if (rx_done === 1'b1) begin
      done_cnt++;
      err_seen = rx_crc_err;
    end
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("BAD run length expected below 20000 seen %0d", cyc);
      give_verdict();
    end
  end

  function automatic logic [15:0] crc_of(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[k]) begin
      c = c ^ {b[k], 8'h00};
      for (int j = 0; j < 8; j++) begin
        c = c[15] ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction : crc_of

  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic check_val(input string what, input logic [47:0] exp, input logic [47:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  // Frame i uses key i, both address widths, lengths 0 to 7, and final or middle segments.
  task automatic tx_frame(input int i);
    logic [7:0]  ctl;
    logic [7:0]  b[$];
    logic        fsf;
    logic [10:0] len;
    logic [15:0] c;
    logic [47:0] dst;
    logic [47:0] src;
    int          n;
    int          t;
    ctl = {i[0], i[1], i[2:0], i[1], i[2], i[0]};
    fsf = (i % 3 != 1);
    len = 11'(i);
    n = ctl[0] ? ADDR_LONG_BYTES : ADDR_SHORT_BYTES;
    dst = 48'hA1B2C3D4E5F6 ^ 48'(i);
    src = 48'h102030405060;
    b = '{ctl, seq, {fsf, seg, len[10:8]}, len[7:0]};
    for (int k = n - 1; k >= 0; k--) b.push_back(dst[8*k+:8]);
    for (int k = n - 1; k >= 0; k--) b.push_back(src[8*k+:8]);
    for (int k = 0; k < i; k++) b.push_back(8'(16 * i + k + 1));
    for (int k = 0; k < (fsf ? 2 : 0); k++) b.push_back(8'h00);
    c = crc_of(b);
    MODEM.cap_q.delete();
    tx_cmd = '{ctl: pfh_rxctl_s'(ctl), final_segment_flag: fsf, segment_byte_length: len,
               block_bytes: len + 11'h002, destination_station_address: dst,
               source_station_address: src};
    tx_start = 1'b1;
    @(negedge clk_sys);
    while (tx_start_ready !== 1'b1) @(negedge clk_sys);
    tick();
    tx_start = 1'b0;
    for (int k = 0; k < i; k++) begin
      tx_data = 8'(16 * i + k + 1);
      tx_data_valid = 1'b1;
      @(negedge clk_sys);
      while (tx_data_ready !== 1'b1) @(negedge clk_sys);
      tick();
    end
    tx_data_valid = 1'b0;
    t = 0;
    while ((tx_start_ready !== 1'b1 || MODEM.cap_q.size() < b.size() + 4) && t < 500) begin
      tick();
      t++;
    end
    check_val("line byte count", b.size() + 4, MODEM.cap_q.size());
    for (int k = 0; k < 2; k++) check_val("preamble", 10'h255, MODEM.cap_q[k]);
    foreach (b[k]) check_val("frame byte", {2'b00, b[k]}, MODEM.cap_q[k+2]);
    check_val("crc high", {2'b00, c[15:8]}, MODEM.cap_q[b.size()+2]);
    check_val("crc low", {2'b01, c[7:0]}, MODEM.cap_q[b.size()+3]);
    seq = fsf ? seq + 8'h01 : seq;
    seg = fsf ? 4'h0 : seg + 4'h1;
    $display("tx frame %0d finished", i);
  endtask : tx_frame

  task automatic rx_frame(input logic [7:0] ctl, input int len, input logic [47:0] dst,
                          input logic bad, input logic acc, input logic mc);
    logic [7:0]  b[$];
    logic [7:0]  h[$];
    logic [15:0] c;
    int          n;
    int          t;
    n = ctl[0] ? ADDR_LONG_BYTES : ADDR_SHORT_BYTES;
    h = '{ctl, 8'h5A, {5'h10, 3'(len >> 8)}, 8'(len)};
    b = h;
    for (int k = n - 1; k >= 0; k--) b.push_back(dst[8*k+:8]);
    for (int k = n - 1; k >= 0; k--) b.push_back(8'(48'h00000000BEEF >> (8 * k)));
    for (int k = 0; k < len; k++) b.push_back(8'hC0 + 8'(k));
    b.push_back(8'h00);
    b.push_back(8'h00);
    c = crc_of(b) ^ (bad ? 16'h0100 : 16'h0000);
    b.push_back(c[15:8]);
    b.push_back(c[7:0]);
    rxd_q.delete();
    done_cnt = 0;
    info_seen = '0;
    err_seen = ~bad;
    MODEM.send(b);
    t = 0;
    while (done_cnt == 0 && t < 20) begin
      tick();
      t++;
    end
    check_val("rx done count", 1, done_cnt);
    check_val("rx header", {h[0], h[1], h[2], h[3]}, info_seen.hdr);
    check_val("rx dest", ctl[0] ? dst : {32'h0, dst[15:0]}, info_seen.destination_station_address);
    check_val("rx src", 48'h00000000BEEF, info_seen.source_station_address);
    check_val("rx multicast", mc, info_seen.multicast);
    check_val("rx accepted", acc, info_seen.accepted);
    check_val("rx data count", acc ? len : 0, rxd_q.size());
    foreach (rxd_q[k]) check_val("rx data", 8'hC0 + 8'(k), rxd_q[k]);
    check_val("rx crc error", bad, err_seen);
    $display("rx frame finished");
  endtask : rx_frame

  // A frame cut off right after the destination must be flagged, deliver nothing and free the parser.
  task automatic rx_cut_frame();
    logic [7:0] b[$];
    int         t;
    b = '{8'h00, 8'h5A, 8'h80, 8'h01, 8'h12, 8'h34};
    rxd_q.delete();
    done_cnt = 0;
    err_seen = 1'b0;
    MODEM.send(b);
    t = 0;
    while (done_cnt == 0 && t < 20) begin
      tick();
      t++;
    end
    check_val("cut done count", 1, done_cnt);
    check_val("cut crc error", 1'b1, err_seen);
    check_val("cut data count", 0, rxd_q.size());
    $display("rx cut frame finished");
  endtask : rx_cut_frame

  initial begin
    repeat (10) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    check_val("idle start ready", 1'b1, tx_start_ready);
    check_val("idle line valid", 1'b0, line_valid);
    check_val("idle crc error", 1'b0, rx_crc_err);
    for (int i = 0; i < 8; i++) tx_frame(i);
    rx_cut_frame();
    rx_frame(8'h48, 3, 48'h000000001234, 1'b0, 1'b1, 1'b0);
    rx_frame(8'h41, 2, 48'h030000000001, 1'b1, 1'b1, 1'b1);
    rx_frame(8'h00, 2, 48'h000000005678, 1'b0, 1'b0, 1'b0);
    give_verdict();
  end
endmodule : pfh_codec_test
